// ### hw/cid_core.sv
// Purpose: decode and execute part of a 14-bit instruction set
// Assumes: program and file memories answer one clock after a read
// Notes: one instruction cycle is four clk_sys phases Q1..Q4
//
// Contract
// - decode subtract, nibble swap, xor on file
// - bit clear forces addressed bit zero
// - bit set forces addressed bit one
// - skip next when addressed bit clear
// - skip next when addressed bit set
// - branch or true test costs two cycles
// - add literal updates carry, digit carry, zero
// - and literal updates zero only
// - or literal updates zero only
// - xor literal updates zero only
// - literal minus accumulator updates three flags
// - load literal; return with literal, no flags
// - standby sets time-out and clears power-down flag; watchdog clear sets both
// - port operands come from pin values
// - timer write clears assigned prescaler
// - add file sums accumulator and file
// - destination bit picks accumulator or file
// - call pushes return, loads latch-extended target
`timescale 1ns/1ps
module cid_core (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Register port
  input cid_pkg::cid_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Program memory
  output cid_pkg::cid_prog_req_t prog_req,
  input wire logic [13:0] prog_rdata,
  // File memory and pins
  output cid_pkg::cid_file_req_t file_req,
  input wire logic [7:0] file_rdata,
  input wire logic [cid_pkg::IO_PORTS-1:0][7:0] port_pins,
  input wire logic [7:0] upper_counter_latch,
  // Events to other units
  output cid_pkg::cid_event_t events
);
  import cid_pkg::*;

  cid_state_t st;
  cid_state_t nx;
  cid_alu_op_t alu_op;
  logic [7:0] alu_b;
  logic [7:0] alu_y;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic [1:0] top;
  logic [3:0] sub_op;
  logic [2:0] bsel;
  logic [7:0] lit;
  logic [7:0] bit_mask;
  logic is_byte_op;
  logic [12:0] pc_inc;
  logic [2:0] sp_dec;
  logic [6:0] io_off;
  logic io_hit;
  logic [13:0] next_ir;
  logic [3:0] lit_key;

  assign top = st.ir[13:12];
  assign sub_op = st.ir[11:8];
  assign bsel = st.ir[9:7];
  assign lit = st.ir[7:0];
  assign bit_mask = 8'h01 << bsel;
  assign pc_inc = st.pc + 13'h0001;
  assign sp_dec = st.sp - 3'h1;
  assign io_off = st.file.addr - IO_FIRST;
  assign io_hit = (st.file.addr >= IO_FIRST) && (st.file.addr <= IO_LAST);
  assign next_ir = st.flush ? OP_NOP : st.fetch;
  // Don't-care opcode bits folded onto one code each
  assign lit_key = (sub_op[3:2] == 2'b00) ? LIT_LOAD :
    (sub_op[3:2] == 2'b01) ? LIT_RET :
    (sub_op[3:1] == 3'b110) ? LIT_SUB :
    (sub_op[3:1] == 3'b111) ? LIT_ADD : sub_op;
  assign is_byte_op = (top == TOP_BYTE) && ((sub_op == BYTE_SUB) ||
    (sub_op == BYTE_XOR) || (sub_op == BYTE_ADD) || (sub_op == BYTE_SWAP));

  // Operation select for the shared ALU
  always_comb begin
    alu_op = CID_ALU_PASS;
    alu_b = st.w;
    if (top == TOP_BYTE) begin
      case (sub_op)
        BYTE_ADD: alu_op = CID_ALU_ADD;
        BYTE_SUB: alu_op = CID_ALU_SUB;
        BYTE_XOR: alu_op = CID_ALU_XOR;
        BYTE_SWAP: alu_op = CID_ALU_SWAP;
        default: alu_op = CID_ALU_PASS;
      endcase
    end else if (top == TOP_LIT) begin
      alu_b = lit;
      case (lit_key)
        LIT_ADD: alu_op = CID_ALU_ADD;
        LIT_SUB: alu_op = CID_ALU_SUB;
        LIT_AND: alu_op = CID_ALU_AND;
        LIT_OR: alu_op = CID_ALU_OR;
        LIT_XOR: alu_op = CID_ALU_XOR;
        default: alu_op = CID_ALU_PASS;
      endcase
    end
  end

  // Literal subtract is k minus W, so the operands swap
  cid_alu u_alu (
    .op(alu_op),
    .a((top == TOP_LIT) ? ((alu_op == CID_ALU_SUB) ? lit : st.w) : st.opnd),
    .b((top == TOP_LIT && alu_op == CID_ALU_SUB) ? st.w : alu_b),
    .y(alu_y),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  always_comb begin
    nx = st;
    nx.prog.rd = 1'b0;
    nx.file.rd = 1'b0;
    nx.file.wr = 1'b0;
    nx.ev = '0;
    nx.reg_rdata = 8'h00;
    if (reg_req.rd) begin
      case (reg_req.addr)
        REG_ACC: nx.reg_rdata = st.w;
        REG_STATUS: begin
          nx.reg_rdata[STAT_C] = st.c;
          nx.reg_rdata[STAT_DC] = st.dc;
          nx.reg_rdata[STAT_Z] = st.z;
          nx.reg_rdata[STAT_PD] = st.power_down_flag;
          nx.reg_rdata[STAT_TO] = st.time_out_flag;
        end
        REG_CTRL: nx.reg_rdata = st.ctrl;
        default: nx.reg_rdata = st.pc[7:0];
      endcase
    end
    if (reg_req.wr && reg_req.addr == REG_ACC) begin
      nx.w = reg_req.wdata;
    end
    if (reg_req.wr && reg_req.addr == REG_CTRL) begin
      nx.ctrl = reg_req.wdata;
    end
    case (st.phase)
      CID_Q1: begin
        nx.phase = CID_Q2;
      end
      CID_Q2: begin
        nx.phase = CID_Q3;
        nx.fetch = prog_rdata;
        nx.opnd = io_hit ? port_pins[io_off[2:0]] : file_rdata;
      end
      CID_Q3: begin
        nx.phase = CID_Q4;
        nx.pc = pc_inc;
        nx.file.wdata = alu_y;
        case (top)
          TOP_BYTE: begin
            if (is_byte_op) begin
              if (st.ir[7]) begin
                nx.file.wr = 1'b1;
              end else begin
                nx.w = alu_y;
              end
              if (sub_op == BYTE_ADD || sub_op == BYTE_SUB) begin
                nx.c = alu_c;
                nx.dc = alu_dc;
              end
              if (sub_op != BYTE_SWAP) begin
                nx.z = alu_z;
              end
            end else if (st.ir == OP_SLEEP) begin
              nx.time_out_flag = 1'b1;
              nx.power_down_flag = 1'b0;
              nx.ev.sleep_req = 1'b1;
            end else if (st.ir == OP_WDT_CLR) begin
              nx.time_out_flag = 1'b1;
              nx.power_down_flag = 1'b1;
              nx.ev.wdt_clear = 1'b1;
            end else if (st.ir == OP_RETURN || st.ir == OP_INTERRUPT_RETURN) begin
              nx.pc = st.stack[sp_dec];
              nx.sp = sp_dec;
              nx.flush = 1'b1;
              nx.ev.intr_return = (st.ir == OP_INTERRUPT_RETURN);
            end
          end
          TOP_BIT: begin
            case (st.ir[11:10])
              BIT_CLR: begin
                nx.file.wdata = st.opnd & ~bit_mask;
                nx.file.wr = 1'b1;
              end
              BIT_SET: begin
                nx.file.wdata = st.opnd | bit_mask;
                nx.file.wr = 1'b1;
              end
              BIT_SKC: nx.flush = ~st.opnd[bsel];
              default: nx.flush = st.opnd[bsel];
            endcase
          end
          TOP_JUMP: begin
            if (!st.ir[11]) begin
              nx.stack[st.sp] = st.pc;
              nx.sp = st.sp + 3'h1;
            end
            nx.pc = {upper_counter_latch[4:3], st.ir[10:0]};
            nx.flush = 1'b1;
          end
          default: begin
            case (lit_key)
              LIT_LOAD: nx.w = lit;
              LIT_RET: begin
                nx.w = lit;
                nx.pc = st.stack[sp_dec];
                nx.sp = sp_dec;
                nx.flush = 1'b1;
              end
              LIT_ADD, LIT_SUB: begin
                nx.w = alu_y;
                nx.c = alu_c;
                nx.dc = alu_dc;
                nx.z = alu_z;
              end
              default: begin
                nx.w = alu_y;
                nx.z = alu_z;
              end
            endcase
          end
        endcase
        nx.ev.presc_clear = nx.file.wr && st.ctrl[CTRL_PRESC] &&
          (st.file.addr == TIMER_ZERO_ADDR);
      end
      default: begin
        if (st.ctrl[CTRL_RUN]) begin
          nx.phase = CID_Q1;
          nx.ir = next_ir;
          nx.flush = 1'b0;
          nx.prog.addr = st.pc;
          nx.prog.rd = 1'b1;
          nx.file.addr = next_ir[6:0];
          nx.file.rd = ~next_ir[13];
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      st <= '0;
      st.phase <= CID_Q4;
      st.pc <= PC_RESET;
      st.ir <= OP_NOP;
      st.time_out_flag <= 1'b1;
      st.power_down_flag <= 1'b1;
      st.ctrl <= CTRL_RESET;
    end else begin
      st <= nx;
    end
  end

  assign reg_rdata = st.reg_rdata;
  assign prog_req = st.prog;
  assign file_req = st.file;
  assign events = st.ev;

  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  logic exe;
  assign exe = (st.phase == CID_Q3);

  a_bit_clear_wr: assert property (
    exe && top == TOP_BIT && st.ir[11:10] == BIT_CLR |=> file_req.wr &&
      file_req.wdata[$past(bsel)] == 1'b0 &&
      file_req.addr == $past(st.file.addr))
    else $error("bit clear did not write a zero");
  a_bit_set_wr: assert property (
    exe && top == TOP_BIT && st.ir[11:10] == BIT_SET |=> file_req.wr &&
      file_req.wdata[$past(bsel)] == 1'b1 && st.z == $past(st.z))
    else $error("bit set did not write a one");
  a_skip_clear: assert property (
    exe && top == TOP_BIT && st.ir[11:10] == BIT_SKC && !st.opnd[bsel]
      |=> ##1 st.ir == OP_NOP)
    else $error("skip on clear bit did not discard");
  a_skip_set: assert property (
    exe && top == TOP_BIT && st.ir[11:10] == BIT_SKS && !st.opnd[bsel]
      |=> !st.flush)
    else $error("skip on set fired on clear bit");
  a_and_literal: assert property (
    exe && top == TOP_LIT && sub_op == LIT_AND |=>
      st.w == ($past(st.w) & $past(lit)) && st.c == $past(st.c))
    else $error("and literal result or carry wrong");
  a_sleep_flags: assert property (
    exe && st.ir == OP_SLEEP |=> st.time_out_flag && !st.power_down_flag
      && events.sleep_req ##1 !events.sleep_req)
    else $error("standby flags wrong");
  a_jump_target: assert property (
    exe && top == TOP_JUMP |=>
      st.pc == {$past(upper_counter_latch[4:3]), $past(st.ir[10:0])})
    else $error("jump target wrong");
  a_call_push: assert property (
    exe && top == TOP_JUMP && !st.ir[11] |=> st.sp == $past(st.sp) + 3'h1
      && st.stack[$past(st.sp)] == $past(st.pc))
    else $error("call did not push return address");
  a_pin_operand: assert property (
    st.phase == CID_Q2 && io_hit |=>
      st.opnd == $past(port_pins[io_off[2:0]]))
    else $error("port operand not taken from pins");
  a_presc_clear: assert property (
    file_req.wr && file_req.addr == TIMER_ZERO_ADDR && st.ctrl[CTRL_PRESC]
      |-> events.presc_clear)
    else $error("prescaler not cleared on timer write");
  a_dest_acc: assert property (
    exe && is_byte_op && !st.ir[7] |=> !file_req.wr)
    else $error("file written with accumulator destination");

endmodule : cid_core

// ### hw/cid_pkg.sv
// Purpose: shared constants and types of the instruction decoder
// Assumes: 14-bit instruction words, 8-bit data path, 13-bit counter
// Notes: one instruction cycle is four clk_sys phases
package cid_pkg;

  // Phases of one instruction cycle
  typedef enum logic [1:0] {
    CID_Q1 = 2'b00,
    CID_Q2 = 2'b01,
    CID_Q3 = 2'b10,
    CID_Q4 = 2'b11
  } cid_phase_t;

  typedef enum logic [2:0] {
    CID_ALU_ADD = 3'b000,
    CID_ALU_SUB = 3'b001,
    CID_ALU_AND = 3'b010,
    CID_ALU_OR = 3'b011,
    CID_ALU_XOR = 3'b100,
    CID_ALU_SWAP = 3'b101,
    CID_ALU_PASS = 3'b110
  } cid_alu_op_t;

  // Opcode fields
  localparam logic [1:0] TOP_BYTE = 2'h0;
  localparam logic [1:0] TOP_BIT = 2'h1;
  localparam logic [1:0] TOP_JUMP = 2'h2;
  localparam logic [1:0] TOP_LIT = 2'h3;
  localparam logic [3:0] BYTE_SUB = 4'h2;
  localparam logic [3:0] BYTE_XOR = 4'h6;
  localparam logic [3:0] BYTE_ADD = 4'h7;
  localparam logic [3:0] BYTE_SWAP = 4'hE;
  localparam logic [1:0] BIT_CLR = 2'h0;
  localparam logic [1:0] BIT_SET = 2'h1;
  localparam logic [1:0] BIT_SKC = 2'h2;
  localparam logic [1:0] BIT_SKS = 2'h3;
  localparam logic [3:0] LIT_LOAD = 4'b0000;
  localparam logic [3:0] LIT_RET = 4'b0100;
  localparam logic [3:0] LIT_OR = 4'b1000;
  localparam logic [3:0] LIT_AND = 4'b1001;
  localparam logic [3:0] LIT_XOR = 4'b1010;
  localparam logic [3:0] LIT_SUB = 4'b1100;
  localparam logic [3:0] LIT_ADD = 4'b1110;
  localparam logic [13:0] OP_NOP = 14'h0000;
  localparam logic [13:0] OP_RETURN = 14'h0008;
  localparam logic [13:0] OP_INTERRUPT_RETURN = 14'h0009;
  localparam logic [13:0] OP_SLEEP = 14'h0063;
  localparam logic [13:0] OP_WDT_CLR = 14'h0064;

  // File addresses
  localparam logic [6:0] TIMER_ZERO_ADDR = 7'h01;
  localparam logic [6:0] IO_FIRST = 7'h05;
  localparam logic [6:0] IO_LAST = 7'h09;
  localparam int IO_PORTS = 5;

  // Register port map
  localparam logic [1:0] REG_ACC = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CTRL = 2'h2;
  localparam logic [1:0] REG_PC_LOW = 2'h3;
  localparam int STAT_C = 0;
  localparam int STAT_DC = 1;
  localparam int STAT_Z = 2;
  localparam int STAT_PD = 3;
  localparam int STAT_TO = 4;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_PRESC = 1;
  localparam logic [7:0] CTRL_RESET = 8'h01;
  localparam logic [12:0] PC_RESET = 13'h0000;

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cid_reg_req_t;

  typedef struct packed {
    logic [12:0] addr;
    logic rd;
  } cid_prog_req_t;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic rd;
    logic wr;
  } cid_file_req_t;

  typedef struct packed {
    logic presc_clear;
    logic wdt_clear;
    logic sleep_req;
    logic intr_return;
  } cid_event_t;

  typedef struct packed {
    cid_phase_t phase;
    logic [12:0] pc;
    logic [13:0] ir;
    logic [13:0] fetch;
    logic [7:0] opnd;
    logic [7:0] w;
    logic c;
    logic dc;
    logic z;
    logic time_out_flag;
    logic power_down_flag;
    logic flush;
    logic [7:0][12:0] stack;
    logic [2:0] sp;
    cid_prog_req_t prog;
    cid_file_req_t file;
    cid_event_t ev;
    logic [7:0] reg_rdata;
    logic [7:0] ctrl;
  } cid_state_t;

endpackage : cid_pkg

// ### hw/cid_alu.sv
// Purpose: 8-bit arithmetic and logic unit of the decoder
// Assumes: subtraction computes a minus b, carry means no borrow
// Notes: purely combinational
`timescale 1ns/1ps
module cid_alu (
  // Operation
  input cid_pkg::cid_alu_op_t op,
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  // Result
  output logic [7:0] y,
  output logic c_out,
  output logic dc_out,
  output logic z_out
);
  import cid_pkg::*;

  logic [7:0] b_eff;
  logic cin;
  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    b_eff = (op == CID_ALU_SUB) ? ~b : b;
    cin = (op == CID_ALU_SUB);
    sum = {1'b0, a} + {1'b0, b_eff} + {8'h00, cin};
    low_sum = {1'b0, a[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin};
    c_out = sum[8];
    dc_out = low_sum[4];
    case (op)
      CID_ALU_ADD: y = sum[7:0];
      CID_ALU_SUB: y = sum[7:0];
      CID_ALU_AND: y = a & b;
      CID_ALU_OR: y = a | b;
      CID_ALU_XOR: y = a ^ b;
      CID_ALU_SWAP: y = {a[3:0], a[7:4]};
      default: y = a;
    endcase
    z_out = (y == 8'h00);
  end

endmodule : cid_alu

// ### verif/cid_mem.sv
// Purpose: program and file memory model facing the decoder
// Assumes: data are presented in the clock after each read strobe
// Notes: outside an answer the data lines show inverted last values
`timescale 1ns/1ps
module cid_mem (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // Program side
  input cid_pkg::cid_prog_req_t prog_req,
  output logic [13:0] prog_rdata,
  // File side
  input cid_pkg::cid_file_req_t file_req,
  output logic [7:0] file_rdata
);
  import cid_pkg::*;
  logic [13:0] rom [64];
  logic [7:0] ram [128];
  // Toggling keeps stale data from passing as a late answer
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      prog_rdata <= 14'h0000;
      file_rdata <= 8'h00;
    end else begin
      prog_rdata <= prog_req.rd ? rom[prog_req.addr[5:0]] : ~prog_rdata;
      file_rdata <= file_req.rd ? ram[file_req.addr] : ~file_rdata;
      if (file_req.wr) begin
        ram[file_req.addr] <= file_req.wdata;
      end
    end
  end
endmodule : cid_mem

// ### verif/tb_cpu_instruction_decoder.sv
// Purpose: self-checking bench of the instruction decoder
// Assumes: programs start at address 0 and end in a jump to self
// Notes: accumulator and status are read over the register port, file cells from the memory model
`timescale 1ns/1ps
module tb_cpu_instruction_decoder;
  import cid_pkg::*;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  cid_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  cid_prog_req_t prog_req;
  logic [13:0] prog_rdata;
  cid_file_req_t file_req;
  logic [7:0] file_rdata;
  logic [IO_PORTS-1:0][7:0] port_pins = '0;
  logic [7:0] upper_counter_latch = 8'h00;
  cid_event_t events;
  int num_errors = 0;
  int cmp_count = 0;
  int n_presc, n_wdt, n_sleep, n_iret;
  logic [12:0] fq[$];
  logic [7:0] d, s;

  initial begin
    forever #10 clk_sys = ~clk_sys;
  end

  cid_core u_cid_core (.clk_sys(clk_sys), .resetn(resetn),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .prog_req(prog_req),
    .prog_rdata(prog_rdata), .file_req(file_req), .file_rdata(file_rdata),
    .port_pins(port_pins), .upper_counter_latch(upper_counter_latch),
    .events(events));
  cid_mem u_cid_mem (.clk_sys(clk_sys), .resetn(resetn),
    .prog_req(prog_req), .prog_rdata(prog_rdata), .file_req(file_req),
    .file_rdata(file_rdata));

  // Event pulses and fetch order
  always @(posedge clk_sys) begin
    if (!resetn) begin
      {n_presc, n_wdt, n_sleep, n_iret} = '0;
      fq.delete();
    end else begin
      n_presc += events.presc_clear;
      n_wdt += events.wdt_clear;
      n_sleep += events.sleep_req;
      n_iret += events.intr_return;
      if (prog_req.rd === 1'b1) fq.push_back(prog_req.addr);
    end
  end

  function automatic logic [13:0] lit(logic [3:0] op, logic [7:0] k);
    return {TOP_LIT, op, k};
  endfunction : lit
  function automatic logic [13:0] fop(logic [3:0] op, logic t, logic [6:0] f);
    return {TOP_BYTE, op, t, f};
  endfunction : fop
  function automatic logic [13:0] bop(logic [1:0] op, logic [2:0] b,
                                      logic [6:0] f);
    return {TOP_BIT, op, b, f};
  endfunction : bop
  function automatic logic [13:0] jmp(logic g, logic [10:0] k);
    return {TOP_JUMP, g, k};
  endfunction : jmp

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic load(input logic [13:0] p[$]);
    foreach (p[i]) u_cid_mem.rom[i] = p[i];
  endtask : load

  task automatic start(input logic [39:0] pp, input logic [7:0] lat);
    @(posedge clk_sys);
    resetn <= 1'b0;
    port_pins <= pp;
    upper_counter_latch <= lat;
    repeat (2) @(posedge clk_sys);
    resetn <= 1'b1;
  endtask : start

  task automatic wait_loop(input logic [12:0] a);
    int hits;
    hits = 0;
    for (int i = 0; i < 400 && hits < 2; i++) begin
      @(posedge clk_sys);
      if (prog_req.rd === 1'b1 && prog_req.addr === a) hits++;
    end
    if (hits < 2) begin
      num_errors++;
      final_report();
    end
    repeat (4) @(posedge clk_sys);
  endtask : wait_loop

  task automatic reg_wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_sys);
    reg_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    reg_req.rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : reg_rd

  task automatic t_regs;
    int n;
    load({jmp(1'b1, 11'h000)});
    start(40'h0, 8'h00);
    wait_loop(13'h0000);
    reg_rd(REG_CTRL, d);
    chk(d, CTRL_RESET);
    @(posedge clk_sys);
    #1 chk(reg_rdata, 8'h00);
    reg_wr(REG_STATUS, 8'hFF);
    reg_rd(REG_STATUS, d);
    chk(d, 8'h18);
    reg_wr(REG_ACC, 8'hA7);
    reg_rd(REG_ACC, d);
    chk(d, 8'hA7);
    reg_wr(REG_CTRL, 8'h00);
    repeat (8) @(posedge clk_sys);
    n = fq.size();
    repeat (16) @(posedge clk_sys);
    chk(16'(fq.size() - n), 16'h0000);
  endtask : t_regs

  task automatic t_lit;
    logic [3:0] ops[9] = '{4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF, 4'h0,
                           4'h3};
    logic [7:0] ks[9] = '{8'h00, 8'hC5, 8'h3A, 8'h3A, 8'h29, 8'hC6, 8'h05,
                          8'h00, 8'h81};
    logic [7:0] a, k, r;
    logic c, dc, z;
    a = 8'h3A;
    foreach (ops[i]) begin
      k = ks[i];
      {c, dc, z} = 3'b111;
      case (ops[i])
        4'h8: r = a | k;
        4'h9: r = a & k;
        4'hA: r = a ^ k;
        4'hC, 4'hD: begin
          r = k - a;
          c = (k >= a);
          dc = (k[3:0] >= a[3:0]);
        end
        4'hE, 4'hF: begin
          {c, r} = {1'b0, a} + {1'b0, k};
          dc = ({1'b0, a[3:0]} + {1'b0, k[3:0]}) > 5'h0F;
        end
        default: r = k;
      endcase
      if (ops[i][3]) z = (r == 8'h00);
      load({lit(4'h0, 8'h0F), lit(4'hE, 8'hF1), lit(4'h0, a),
            lit(ops[i], k), jmp(1'b1, 11'h004)});
      start(40'h0, 8'h00);
      wait_loop(13'h0004);
      reg_rd(REG_ACC, d);
      reg_rd(REG_STATUS, s);
      chk(d, r);
      chk(s, {3'b000, 2'b11, z, dc, c});
    end
  endtask : t_lit

  task automatic t_byte;
    for (int p = 0; p < 2; p++) begin
      u_cid_mem.ram[7'h20] = 8'h5C;
      u_cid_mem.ram[7'h21] = 8'h6C;
      u_cid_mem.ram[7'h07] = 8'h00;
      u_cid_mem.ram[TIMER_ZERO_ADDR] = 8'h11;
      load({lit(4'h0, 8'h13), fop(BYTE_SUB, 1'b1, 7'h20),
            fop(BYTE_SWAP, 1'b0, 7'h20), fop(BYTE_XOR, 1'b1, 7'h20),
            fop(BYTE_ADD, 1'b0, 7'h21), fop(BYTE_ADD, 1'b1, 7'h07),
            fop(BYTE_ADD, 1'b1, TIMER_ZERO_ADDR), jmp(1'b1, 11'h007)});
      start(40'h00_00A5_0000, 8'h00);
      if (p == 1) reg_wr(REG_CTRL, 8'h03);
      wait_loop(13'h0007);
      reg_rd(REG_ACC, d);
      reg_rd(REG_STATUS, s);
      chk(u_cid_mem.ram[7'h20], 8'hDD);
      chk(u_cid_mem.ram[7'h07], 8'hA5);
      chk(u_cid_mem.ram[TIMER_ZERO_ADDR], 8'h11);
      chk(d, 8'h00);
      chk(s, 8'h18);
      chk(16'(n_presc), 16'(p));
    end
  endtask : t_byte

  task automatic t_bits;
    u_cid_mem.ram[7'h30] = 8'h0F;
    load({lit(4'h0, 8'h40), bop(BIT_CLR, 3'd2, 7'h30),
          bop(BIT_SET, 3'd7, 7'h30), bop(BIT_SKC, 3'd2, 7'h30),
          lit(4'h0, 8'h11), bop(BIT_SKS, 3'd7, 7'h30), lit(4'h0, 8'h22),
          bop(BIT_SKC, 3'd0, 7'h30), lit(4'hE, 8'h01),
          bop(BIT_SKS, 3'd2, 7'h30), lit(4'hE, 8'h02), jmp(1'b1, 11'd11)});
    start(40'h0, 8'h00);
    wait_loop(13'd11);
    reg_rd(REG_ACC, d);
    chk(u_cid_mem.ram[7'h30], 8'h8B);
    chk(d, 8'h43);
  endtask : t_bits

  task automatic t_flow;
    logic [12:0] ex[12] = '{13'h0000, 13'h0001, 13'h0804, 13'h0805,
      13'h0001, 13'h0002, 13'h0806, 13'h0807, 13'h0808, 13'h0002,
      13'h0003, 13'h0802};
    load({jmp(1'b0, 11'h004), jmp(1'b0, 11'h006), jmp(1'b1, 11'h002),
          OP_NOP, lit(4'h4, 8'h5A), lit(4'h0, 8'h99), lit(4'hE, 8'h01),
          OP_INTERRUPT_RETURN, lit(4'h0, 8'h77)});
    start(40'h0, 8'h08);
    wait_loop(13'h0802);
    reg_rd(REG_ACC, d);
    while (fq.size() < 12) fq.push_back(13'h1FFF);
    foreach (ex[i]) begin
      chk(fq[i], ex[i]);
    end
    chk(d, 8'h5B);
    chk(16'(n_iret), 16'h0001);
  endtask : t_flow

  task automatic t_power;
    load({OP_SLEEP, jmp(1'b1, 11'h001)});
    start(40'h0, 8'h00);
    wait_loop(13'h0001);
    reg_rd(REG_STATUS, s);
    chk(s[4:3], 2'b10);
    chk(16'(n_sleep * 2 + n_wdt), 16'h0002);
    load({OP_SLEEP, OP_WDT_CLR, jmp(1'b1, 11'h002)});
    start(40'h0, 8'h00);
    wait_loop(13'h0002);
    reg_rd(REG_STATUS, s);
    chk(s[4:3], 2'b11);
    chk(16'(n_sleep + n_wdt), 16'h0002);
  endtask : t_power

  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    t_regs();
    t_lit();
    t_byte();
    t_bits();
    t_flow();
    t_power();
    final_report();
  end
endmodule : tb_cpu_instruction_decoder
